// ==== inc/rtctd_pkg.sv ====
// package: register map, field layout and timing constants of the tamper detector
package rtctd_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0]  OFF_TAMPER_CFG = 8'h40;
  localparam logic [7:0]  OFF_IRQ_STATUS = 8'h50;
  localparam logic [7:0]  OFF_IRQ_MASK   = 8'h54;
  localparam logic [7:0]  OFF_CONTROL    = 8'h58;

  // ---------------------------------------------------------------
  // field positions of the tamper configuration word
  // ---------------------------------------------------------------
  localparam int          POS_DET_EN     = 0;
  localparam int          POS_POLARITY   = 1;
  localparam int          POS_IRQ_EN     = 2;
  localparam int          POS_TS_EN      = 7;
  localparam int          POS_RATE_LO    = 8;
  localparam int          POS_FILT_LO    = 11;
  localparam int          POS_PRE_LO     = 13;
  localparam int          POS_PU_OFF     = 15;
  localparam int          POS_TPIN_MAP   = 16;
  localparam int          POS_TSPIN_MAP  = 17;
  localparam int          POS_ALARM_PP   = 18;
  localparam logic [31:0] CFG_WMASK      = 32'h0007_ff87;

  // status / mask bit positions
  localparam int          ST_TAMPER      = 0;
  localparam int          ST_TIMESTAMP   = 1;
  localparam logic [31:0] ST_WMASK       = 32'h0000_0003;

  // reset values
  localparam logic [31:0] RST_CFG        = 32'h0000_0000;
  localparam logic [1:0]  RST_ST         = 2'h0;
  localparam logic [0:0]  RST_CTRL       = 1'h0;

  // ---------------------------------------------------------------
  // timing: sample divider runs from the kernel clock
  // ---------------------------------------------------------------
  localparam int          DIV_BASE_LOG2  = 15;  // code 0 divides by 32768
  localparam int          DIV_CNT_W      = 15;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // configuration fields carried as one struct
  typedef struct packed {
    logic       alarm_pin_drive_type;
    logic       timestamp_pin_map;
    logic       tamper_pin_map;
    logic       tamper_pullup_off;
    logic [1:0] tamper_precharge_cycles;
    logic [1:0] tamper_filter_count;
    logic [2:0] tamper_sample_rate;
    logic       tamper_timestamp_enable;
    logic       tamper_irq_enable;
    logic       tamper_active_polarity;
    logic       tamper_detect_enable;
  } rtctd_cfg_t;

endpackage : rtctd_pkg

// ==== design/rtctd_sampler.sv ====
// sampler: prescaler, precharge window and sample strobe for the tamper input
module rtctd_sampler
  import rtctd_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       clk_en_i,
  input  wire logic       run_i,
  input  wire logic [2:0] rate_i,
  input  wire logic [1:0] pre_i,
  input  wire logic       pu_off_i,
  output logic            pullup_on_o,
  output logic            sample_o
);

  logic [DIV_CNT_W-1:0] div_r;
  logic [DIV_CNT_W-1:0] period_m1;
  logic [DIV_CNT_W-1:0] pre_len;

  // -------------------------------------------------------------
  // divider: period 2^(15-code) kernel cycles
  // -------------------------------------------------------------
  assign period_m1 = DIV_CNT_W'((32'h1 << (DIV_BASE_LOG2 - 32'(rate_i))) - 32'h1);
  assign pre_len   = DIV_CNT_W'(32'h1 << pre_i);

  // free running while run_i is high (detection on with a filter), parked at zero otherwise
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_r <= '0;
    end else if (clk_en_i) begin
      if (!run_i || div_r >= period_m1) begin
        div_r <= '0;
      end else begin
        div_r <= div_r + 1'b1;
      end
    end
  end

  // pull-up is driven during the last 1..8 cycles up to and including the sample point
  assign pullup_on_o = run_i && !pu_off_i && (div_r > period_m1 - pre_len);
  assign sample_o    = run_i && clk_en_i && (div_r == period_m1);

endmodule : rtctd_sampler

// ==== design/rtctd_top.sv ====
// top: tamper detector with AXI4-Lite register slave and interrupt
// Functional notes
// - bit 0 enables tamper detection; zero means no event is ever detected.
// - with a filter, polarity picks the level: 0 low, 1 high.
// - without filter, polarity picks the edge: 0 rising, 1 falling.
// - bit 7 makes a tamper event also save a timestamp.
// - tamper timestamp works even when the general timestamp enable is off.
// - bits 10:8 pick sample rate, kernel clock over 32768 down to 256.
// - bits 12:11 pick filter: edge, or 2, 4, 8 equal samples.
// - bits 14:13 pick precharge length of 1, 2, 4 or 8 cycles.
// - bit 15 set disables the pull-up precharge before sampling.
// - bit 16 zero routes the first alternate pin to tamper detection.
// - bit 17 zero routes the first alternate pin to timestamp capture.
// - bit 18 picks alarm output drive: 0 open-drain, 1 push-pull.
// - configuration at 0x40 clears on backup reset, kept across system reset.
//
// The AXI4-Lite slave port was decided locally.
module rtctd_top
  import rtctd_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        clk_en_i,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pins
  input  wire logic        first_alt_rtc_pin_i,
  output logic             tamper_pullup_o,
  input  wire logic        alarm_level_i,
  output logic             alarm_pin_o,
  output logic             alarm_pin_oe_o,
  output logic             timestamp_pin_sel_o,
  input  wire logic        general_timestamp_enable_i,
  output logic             timestamp_capture_o,
  output logic             tamper_event_o,
  output logic             irq_o
);

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  rtctd_cfg_t  cfg;
  logic [31:0] cfg_r;
  logic [1:0]  status_r;
  logic [1:0]  mask_r;
  logic [0:0]  ctrl_r;          // bit 0: write one to restart filter history
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  // reserved bits 6:3 are not carried, so the struct is 15 bits wide
  assign cfg = rtctd_cfg_t'({cfg_r[18:7], cfg_r[2:0]});

  // -------------------------------------------------------------
  // axi write path: address and data taken independently
  // -------------------------------------------------------------
  logic        wr_go;
  logic [31:0] wr_bmask;
  logic        wr_hit;

  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  assign wr_go         = aw_hold_r && w_hold_r && !bvalid_r && clk_en_i;
  assign wr_bmask      = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign wr_hit        = (awaddr_r == OFF_TAMPER_CFG) || (awaddr_r == OFF_IRQ_STATUS) ||
                         (awaddr_r == OFF_IRQ_MASK) || (awaddr_r == OFF_CONTROL);

  // capture address and data halves
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end else if (clk_en_i) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= {s_axi_awaddr[7:2], 2'b00};
      end else if (wr_go) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  // write response, unmapped addresses answer slverr
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (clk_en_i) begin
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // configuration word; nrst_i stands for the backup-domain reset, no system reset reaches it
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_r <= RST_CFG;
    end else if (clk_en_i && wr_go && awaddr_r == OFF_TAMPER_CFG) begin
      cfg_r <= (cfg_r & ~(wr_bmask & CFG_WMASK)) | (wdata_r & wr_bmask & CFG_WMASK);
    end
  end

  // mask and control registers
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask_r <= RST_ST;
      ctrl_r <= RST_CTRL;
    end else if (clk_en_i) begin
      ctrl_r <= RST_CTRL;   // self-clearing
      if (wr_go && awaddr_r == OFF_IRQ_MASK) begin
        mask_r <= (mask_r & ~wr_bmask[1:0]) | (wdata_r[1:0] & wr_bmask[1:0]);
      end
      if (wr_go && awaddr_r == OFF_CONTROL && wr_bmask[0]) begin
        ctrl_r <= wdata_r[0:0];
      end
    end
  end

  // -------------------------------------------------------------
  // axi read path
  // -------------------------------------------------------------
  logic [31:0] rd_mux;
  logic        rd_hit;

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr & 8'hfc)
      OFF_TAMPER_CFG: rd_mux = cfg_r;
      OFF_IRQ_STATUS: rd_mux = {30'h0, status_r};
      OFF_IRQ_MASK:   rd_mux = {30'h0, mask_r};
      OFF_CONTROL:    rd_mux = 32'h0000_0000;
      default:        rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !rvalid_r;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end else if (clk_en_i) begin
      if (s_axi_arvalid && !rvalid_r) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_mux;
        rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

  // -------------------------------------------------------------
  // pin routing: only map code 0 is wired, code 1 leaves the input idle
  // -------------------------------------------------------------
  logic tamper_in;
  logic det_on;

  assign tamper_in = (cfg.tamper_pin_map == 1'b0) ? first_alt_rtc_pin_i : 1'b0;
  assign det_on    = cfg.tamper_detect_enable && (cfg.tamper_pin_map == 1'b0);
  assign timestamp_pin_sel_o = (cfg.timestamp_pin_map == 1'b0);

  // -------------------------------------------------------------
  // sampling
  // -------------------------------------------------------------
  logic sample;

  rtctd_sampler u_sampler (
    .sys_clk_i   (sys_clk_i),
    .nrst_i      (nrst_i),
    .clk_en_i    (clk_en_i),
    .run_i       (det_on && cfg.tamper_filter_count != 2'h0),
    .rate_i      (cfg.tamper_sample_rate),
    .pre_i       (cfg.tamper_precharge_cycles),
    .pu_off_i    (cfg.tamper_pullup_off),
    .pullup_on_o (tamper_pullup_o),
    .sample_o    (sample)
  );

  // -------------------------------------------------------------
  // detection: edge mode or filtered level mode
  // -------------------------------------------------------------
  logic       prev_r;
  logic [3:0] run_cnt_r;
  logic       armed_r;
  logic       active_lvl;
  logic [3:0] need_cnt;
  logic       edge_hit;
  logic       lvl_hit;
  logic       event_hit;

  assign active_lvl = (tamper_in == cfg.tamper_active_polarity);
  assign need_cnt   = 4'(32'h1 << cfg.tamper_filter_count);
  assign edge_hit   = det_on && (cfg.tamper_filter_count == 2'h0) &&
                      (cfg.tamper_active_polarity ? (prev_r && !tamper_in)
                                                  : (!prev_r && tamper_in));
  assign lvl_hit    = sample && active_lvl && armed_r && (run_cnt_r + 4'h1 >= need_cnt);
  assign event_hit  = clk_en_i && (edge_hit || lvl_hit);

  // previous pin level for the edge detector; tracked even while disabled so enabling never fakes an edge
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev_r <= 1'b0;
    end else if (clk_en_i) begin
      prev_r <= tamper_in;
    end
  end

  // consecutive active-sample counter; one event per active stretch
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_cnt_r <= 4'h0;
      armed_r   <= 1'b1;
    end else if (clk_en_i) begin
      if (!det_on || ctrl_r[0]) begin
        run_cnt_r <= 4'h0;
        armed_r   <= 1'b1;
      end else if (sample) begin
        if (!active_lvl) begin
          run_cnt_r <= 4'h0;
          armed_r   <= 1'b1;
        end else if (lvl_hit) begin
          armed_r   <= 1'b0;   // re-arm after the input leaves the active level, or on restart or disable
        end else if (run_cnt_r != 4'hf) begin
          run_cnt_r <= run_cnt_r + 4'h1;
        end
      end
    end
  end

  // -------------------------------------------------------------
  // sticky status: hardware set beats a software clear in the same cycle
  // -------------------------------------------------------------
  logic ts_hit;
  logic clr_go;

  assign ts_hit = event_hit && cfg.tamper_timestamp_enable;
  assign clr_go = wr_go && awaddr_r == OFF_IRQ_STATUS && wr_bmask[0];

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_r <= RST_ST;
    end else if (clk_en_i) begin
      status_r[ST_TAMPER]    <= event_hit ||
                                (status_r[ST_TAMPER] && !(clr_go && wdata_r[ST_TAMPER]));
      status_r[ST_TIMESTAMP] <= ts_hit ||
                                (status_r[ST_TIMESTAMP] && !(clr_go && wdata_r[ST_TIMESTAMP]));
    end
  end

  // event pulses registered for the timestamp unit; general enable deliberately ignored
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tamper_event_o      <= 1'b0;
      timestamp_capture_o <= 1'b0;
    end else if (clk_en_i) begin
      tamper_event_o      <= event_hit;
      timestamp_capture_o <= ts_hit;
    end
  end

  // tamper interrupt needs both the configuration enable and the mask bit; timestamp needs only its mask bit
  assign irq_o = (status_r[ST_TAMPER] && mask_r[ST_TAMPER] && cfg.tamper_irq_enable) ||
                 (status_r[ST_TIMESTAMP] && mask_r[ST_TIMESTAMP]);

  // -------------------------------------------------------------
  // alarm pin driver
  // -------------------------------------------------------------
  logic unused_gts;
  assign unused_gts     = general_timestamp_enable_i;
  assign alarm_pin_o    = cfg.alarm_pin_drive_type ? alarm_level_i : 1'b0;
  assign alarm_pin_oe_o = cfg.alarm_pin_drive_type ? 1'b1 : !alarm_level_i;

endmodule : rtctd_top

// ==== dv/rtctd_sva.sv ====
// checker: bus, pulse and pin assertions of the tamper detector
module rtctd_sva (
  input wire logic        sys_clk_i,
  input wire logic        nrst_i,
  input wire logic        clk_en_i,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        alarm_level_i,
  input wire logic        alarm_pin_o,
  input wire logic        alarm_pin_oe_o,
  input wire logic        tamper_pullup_o,
  input wire logic        tamper_event_o,
  input wire logic        timestamp_capture_o,
  input wire logic        irq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // -------------------------------------------------
  // helper: length of the running precharge pulse
  // -------------------------------------------------
  int unsigned pu_len_r;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) pu_len_r <= 0;
    else if (clk_en_i) pu_len_r <= tamper_pullup_o ? pu_len_r + 1 : 0;
  end
  // -------------------------------------------------
  // properties
  // -------------------------------------------------
  property p_b_hold;
    s_axi_bvalid && !(s_axi_bready && clk_en_i) |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold;
    s_axi_rvalid && !(s_axi_rready && clk_en_i) |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_ar_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_busy: assert property (p_ar_busy) else $error("read address taken while busy");
  property p_pp;
    alarm_pin_o |-> alarm_pin_oe_o && alarm_level_i;
  endproperty
  a_pp: assert property (p_pp) else $error("alarm pin high without level");
  property p_od;
    !alarm_pin_oe_o |-> !alarm_pin_o && alarm_level_i;
  endproperty
  a_od: assert property (p_od) else $error("alarm pin released at low level");
  property p_pu_len;
    pu_len_r <= 8;
  endproperty
  a_pu_len: assert property (p_pu_len) else $error("precharge longer than 8 cycles");
  property p_ts_ev;
    timestamp_capture_o |-> tamper_event_o;
  endproperty
  a_ts_ev: assert property (p_ts_ev) else $error("timestamp without tamper event");
  property p_ev_once;
    tamper_event_o && clk_en_i |=> !tamper_event_o;
  endproperty
  a_ev_once: assert property (p_ev_once) else $error("tamper pulse too long");
  c_ev: cover property (tamper_event_o);
  c_ts: cover property (timestamp_capture_o);
  c_irq: cover property ($rose(irq_o));
  c_pu: cover property ($fell(tamper_pullup_o));
endmodule : rtctd_sva

bind rtctd_top rtctd_sva rtctd_sva_inst (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .alarm_level_i(alarm_level_i), .alarm_pin_o(alarm_pin_o),
  .alarm_pin_oe_o(alarm_pin_oe_o), .tamper_pullup_o(tamper_pullup_o),
  .tamper_event_o(tamper_event_o), .timestamp_capture_o(timestamp_capture_o), .irq_o(irq_o)
);

// ==== dv/rtctd_switch.sv ====
// partner: tamper switch on the pin, with a floating line when released
module rtctd_switch (
  input  wire logic sys_clk_i,
  input  wire logic pullup_i,
  input  wire logic drive_i,
  input  wire logic level_i,
  output logic      pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic float_r = 1'b0;
  // a released line holds no value, so it wanders unless pulled up
  always @(posedge sys_clk_i) begin
    float_r <= ~float_r;
  end
  assign pin_o = drive_i ? level_i : (pullup_i | float_r);
endmodule : rtctd_switch

// ==== dv/tb_top.sv ====
// testbench: registers, edge and level detection, precharge and pins
module tb_top import rtctd_pkg::*; ();
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, nrst = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic alevel = 0, gts = 0, drv = 1, lvl = 0, cen = 1;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp, wresp;
  logic awrdy, wrdy, bvalid, arrdy, rvalid, pin, pull, apin, aoe, tsel, tscap, ev, irq;
  int miscompares = 0, n_tests = 0, n_ev = 0, n_ts = 0;
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  rtctd_top rtctd_top_inst (
    .sys_clk_i(clk), .nrst_i(nrst), .clk_en_i(cen), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awrdy), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arrdy), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .first_alt_rtc_pin_i(pin),
    .tamper_pullup_o(pull), .alarm_level_i(alevel), .alarm_pin_o(apin), .alarm_pin_oe_o(aoe),
    .timestamp_pin_sel_o(tsel), .general_timestamp_enable_i(gts), .timestamp_capture_o(tscap),
    .tamper_event_o(ev), .irq_o(irq)
  );
  rtctd_switch rtctd_switch_inst (.sys_clk_i(clk), .pullup_i(pull), .drive_i(drv), .level_i(lvl), .pin_o(pin));
  // pulses counted on the falling edge, once the registered outputs settled
  always @(negedge clk) begin
    if (ev === 1'b1) n_ev++;
    if (tscap === 1'b1) n_ts++;
  end
  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic tmo();
    miscompares++;
    $display("CHECK FAILED bus answer expected 1 seen 0");
    results();
  endtask : tmo
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // handshakes judged at the falling edge: inputs only move after rising edges
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    repeat (64) begin
      @(negedge clk);
      ta = awv & awrdy;
      tw = wv & wrdy;
      tb = bvalid;
      wresp = bresp;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    repeat (64) begin
      @(negedge clk);
      ta = arv & arrdy;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arv <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask : rd
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    wr(OFF_TAMPER_CFG, 32'h0004_0000);
    nrst <= 1'b0;
    cyc(2);
    nrst <= 1'b1;
    rd(OFF_TAMPER_CFG, d, r);
    chk("cfg reset", RST_CFG, d);
    wr(OFF_TAMPER_CFG, 32'hffff_fffe);
    chk("cfg wresp", {30'h0, RESP_OKAY}, {30'h0, wresp});
    rd(OFF_TAMPER_CFG, d, r);
    chk("cfg rw", CFG_WMASK & 32'hffff_fffe, d);
    wr(OFF_TAMPER_CFG, 32'h0);
    wr(8'h10, 32'hffff_ffff);
    chk("unmapped wresp", {30'h0, RESP_SLVERR}, {30'h0, wresp});
    rd(8'h10, d, r);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("unmapped data", 32'h0, d);
    rd(OFF_CONTROL, d, r);
    chk("control", 32'h0, d);
    $display("register test done");
  endtask : t_regs
  task automatic t_edge(input logic p, ts, ie, en, map);
    logic [31:0] cfg, d;
    logic [1:0] r;
    logic e;
    cfg = {15'h0, map, 8'h0, ts, 4'h0, ie, p, en};
    e = en & ~map;
    gts <= ~ts;
    lvl <= p;
    cyc(4);
    wr(OFF_TAMPER_CFG, cfg & ~32'h1);
    wr(OFF_TAMPER_CFG, cfg);
    wr(OFF_IRQ_MASK, 32'h3);
    wr(OFF_IRQ_STATUS, 32'h3);
    n_ev = 0;
    n_ts = 0;
    lvl <= ~p;
    cyc(6);
    chk("events", {31'h0, e}, n_ev);
    chk("stamps", {31'h0, e & ts}, n_ts);
    rd(OFF_IRQ_STATUS, d, r);
    chk("status", {30'h0, e & ts, e}, d);
    chk("irq", {31'h0, e & (ie | ts)}, {31'h0, irq});
    lvl <= p;
    cyc(6);
    chk("events back", {31'h0, e}, n_ev);
    wr(OFF_IRQ_STATUS, 32'h3);
    @(negedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(OFF_TAMPER_CFG, cfg & ~32'h1);
    wr(OFF_TAMPER_CFG, 32'h0);
    $display("edge test done");
  endtask : t_edge
  task automatic t_filt(input logic [2:0] rate, input logic [1:0] f, input logic p);
    int per, need, c;
    per = 1 << (15 - rate);
    need = 1 << f;
    lvl <= ~p;
    wr(OFF_TAMPER_CFG, {16'h0, 1'b1, 2'h0, f, rate, 6'h0, p, 1'b1});
    wr(OFF_CONTROL, 32'h1);
    wr(OFF_IRQ_STATUS, 32'h3);
    n_ev = 0;
    lvl <= p;
    for (c = 0; c < (need + 1) * per && n_ev == 0; c++) @(negedge clk);
    chk("delay low", 32'h1, {31'h0, c >= (need - 1) * per});
    chk("delay high", 32'h1, {31'h0, c <= need * per + 8});
    cyc(2 * per);
    chk("held events", 32'h1, n_ev);
    lvl <= ~p;
    wr(OFF_TAMPER_CFG, 32'h0);
    $display("filter test done");
  endtask : t_filt
  task automatic t_pre();
    int p, c;
    drv <= 1'b0;
    for (p = 0; p < 4; p++) begin
      wr(OFF_TAMPER_CFG, {17'h0, p[1:0], 2'h1, 3'h7, 8'h1});
      for (c = 0; c < 20 && pull === 1'b1; c++) @(negedge clk);
      for (c = 0; c < 600 && pull !== 1'b1; c++) @(negedge clk);
      for (c = 0; c < 20 && pull === 1'b1; c++) @(negedge clk);
      chk("precharge", 32'h1 << p, c);
    end
    // divider just wrapped; a frozen block must never reach the next precharge window
    @(posedge clk);
    cen <= 1'b0;
    c = 0;
    repeat (300) begin
      @(negedge clk);
      if (pull === 1'b1) c++;
    end
    chk("frozen precharge", 32'h0, c);
    @(posedge clk);
    cen <= 1'b1;
    wr(OFF_TAMPER_CFG, 32'h0000_8f01);
    c = 0;
    repeat (600) begin
      @(negedge clk);
      if (pull === 1'b1) c++;
    end
    chk("precharge off", 32'h0, c);
    wr(OFF_TAMPER_CFG, 32'h0);
    drv <= 1'b1;
    $display("precharge test done");
  endtask : t_pre
  task automatic t_pins();
    int i;
    for (i = 0; i < 4; i++) begin
      alevel <= i[0];
      wr(OFF_TAMPER_CFG, {13'h0, i[1], i[1], 17'h0});
      @(negedge clk);
      chk("alarm out", {31'h0, i[1] & i[0]}, {31'h0, apin});
      chk("alarm oe", {31'h0, i[1] | ~i[0]}, {31'h0, aoe});
      chk("ts pin sel", {31'h0, ~i[1]}, {31'h0, tsel});
      @(posedge clk);
    end
    $display("pin test done");
  endtask : t_pins
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_edge(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    t_edge(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    t_edge(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    t_edge(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    t_edge(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    t_filt(3'h7, 2'h1, 1'b0);
    t_filt(3'h7, 2'h2, 1'b1);
    t_filt(3'h7, 2'h3, 1'b1);
    t_filt(3'h6, 2'h1, 1'b0);
    t_pre();
    t_pins();
    results();
  end
endmodule : tb_top
